// file: lpddr_consts.svh
// Purpose: shared constants of the burst command path
// Assumes: 125 MHz clock, one data pair per clock on the bus
// Notes: times in ns are turned into whole clocks, rounding up
`ifndef LPDDR_CONSTS_SVH
`define LPDDR_CONSTS_SVH
`define CLK_PERIOD_NS 8
`define READ_LATENCY_DEF 2
`define BURST_LENGTH_DEF 4
`define PRECHARGE_PERIOD_NS 15
`define WRITE_RECOVERY_NS 15
`define WRITE_TO_READ_GAP_CLK 2
`define PRECHARGE_PERIOD_CLK ((`PRECHARGE_PERIOD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WRITE_RECOVERY_CLK ((`WRITE_RECOVERY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STROBE_IDLE 2'h0
`define STROBE_TOGGLE 2'h2
`define MASK_NONE 2'h0
`define MASK_ALL 2'h3
`endif

// file: lpddr_pkg.sv
// Purpose: command and state types of the burst command path
// Assumes: nothing
// Notes: command codes are internal, not pin encodings
package lpddr_pkg;
  typedef enum logic [2:0] {
    cmd_nop = 3'h0,
    cmd_read = 3'h1,
    cmd_write = 3'h2,
    cmd_burst_stop = 3'h3,
    cmd_precharge = 3'h4
  } cmd_e;
  typedef enum logic [1:0] {
    st_idle = 2'h0,
    st_read = 2'h1,
    st_write = 2'h2
  } ctl_state_e;
endpackage

// file: lpddr_bus.sv
// Purpose: command bus and data pins between controller and memory
// Assumes: one rise/fall data pair per clock, strobe as {rise,fall}
// Notes: undriven shared pins resolve to zero
`timescale 1ns/1ns
`default_nettype none
`include "lpddr_consts.svh"
interface lpddr_bus #(parameter int W = 8, parameter int COLW = 4);
  lpddr_pkg::cmd_e cmd;
  logic [1:0] bank;
  logic [COLW-1:0] col;
  logic auto_precharge_addr_bit;
  logic [1:0] write_data_mask;
  logic [2*W-1:0] ctl_dq, dev_dq, dq;
  logic ctl_dq_oe, dev_dq_oe, ctl_dqs_oe, dev_dqs_oe;
  logic [1:0] ctl_dqs, dev_dqs, dqs;
  // Wire level from the enables
  assign dq = ctl_dq_oe ? ctl_dq : (dev_dq_oe ? dev_dq : '0);
  assign dqs = ctl_dqs_oe ? ctl_dqs : (dev_dqs_oe ? dev_dqs : `STROBE_IDLE);
  modport ctl (output cmd, bank, col, auto_precharge_addr_bit, write_data_mask,
    output ctl_dq, ctl_dq_oe, ctl_dqs, ctl_dqs_oe, input dq, dqs);
  modport dev (input cmd, bank, col, auto_precharge_addr_bit, write_data_mask,
    input dq, dqs, output dev_dq, dev_dq_oe, dev_dqs, dev_dqs_oe);
endinterface
`default_nettype wire

// file: lpddr_pair_fifo.sv
// Purpose: write data buffer, one data pair per word
// Assumes: DEPTH is a power of two
// Notes: level counts words held, push and pop may share a cycle
`timescale 1ns/1ns
`default_nettype none
module lpddr_pair_fifo #(parameter int W = 16, parameter int DEPTH = 4) (
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire logic i_ce,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [W-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [W-1:0] o_out_data,
  output logic [$clog2(DEPTH):0] o_level
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW:0] wp;
    logic [AW:0] rp;
  } fifo_s;
  fifo_s s_r, s_nxt;
  logic [W-1:0] mem [DEPTH];
  logic push, pop;
  // Flags from pointer distance
  assign o_level = s_r.wp - s_r.rp;
  assign o_in_ready = o_level != (AW+1)'(DEPTH);
  assign o_out_valid = o_level != '0;
  assign o_out_data = mem[s_r.rp[AW-1:0]];
  assign push = i_in_valid && o_in_ready;
  assign pop = i_out_ready && o_out_valid;
  // Pointer advance
  always_comb begin
    s_nxt = s_r;
    if (push) s_nxt.wp = s_r.wp + 1'b1;
    if (pop) s_nxt.rp = s_r.rp + 1'b1;
  end
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) s_r <= '0;
    else if (i_ce) s_r <= s_nxt;
  end
  // Storage, no reset needed
  always_ff @(posedge i_clock) begin
    if (i_ce && push) mem[s_r.wp[AW-1:0]] <= i_in_data;
  end
endmodule
`default_nettype wire

// file: lpddr_ctl_end.sv
// Purpose: controller end, turns user requests into bus bursts
// Assumes: banks already active, one request held at a time
// Notes: write data waits in a pair FIFO until all wanted pairs of the burst are there
`timescale 1ns/1ns
`default_nettype none
`include "lpddr_consts.svh"
// Summary of operation
// - burst stop issued after wanted read pairs
// - read finished or stopped before write
// - length two reads need no stop
// - device truncates only lengths four, eight
// - precharge after read, wanted pairs later
// - no bank command during precharge period (held only after explicit precharge, not after auto precharge)
// - read auto precharge after half burst
// - write auto precharge after burst end
// - auto precharge bit low disables it
// - data taken on strobe edges
// - strobe low preamble and postamble
// - first rising strobe one clock after write
// - data after burst end ignored
// - back to back writes keep data continuous
// - wait gap after write before read
// - read cut write, later elements masked
// - wait recovery time before precharge (write auto precharge starts one clock after the last pair, without the wait)
// - precharge cut write, later elements masked
// - strobe keeps toggling while masking
// - random writes, lengths two four eight
// - read data after read latency
// - at least two clocks write to read
// - precharge period fifteen ns
module lpddr_ctl_end #(
  parameter int W = 8,
  parameter int COLW = 4,
  parameter int BL = `BURST_LENGTH_DEF,
  parameter int RL = `READ_LATENCY_DEF,
  parameter int DEPTH = 4
) (
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire logic i_ce,
  input wire logic i_req_valid,
  input wire lpddr_pkg::cmd_e i_req_op,
  input wire logic [1:0] i_req_bank,
  input wire logic [COLW-1:0] i_req_col,
  input wire logic i_req_ap,
  input wire logic [2:0] i_req_pairs,
  output logic o_req_ready,
  input wire logic i_wd_valid,
  output logic o_wd_ready,
  input wire logic [2*W-1:0] i_wd_data,
  output logic o_rd_valid,
  output logic [2*W-1:0] o_rd_data,
  output logic o_busy,
  lpddr_bus.ctl bus
);
  localparam int LW = $clog2(DEPTH) + 1;
  localparam logic [2:0] HALF = 3'(BL / 2);
  typedef struct packed {
    lpddr_pkg::ctl_state_e st;
    logic [2:0] cnt;
    logic [2:0] pairs;
    logic pv;
    lpddr_pkg::cmd_e pop;
    logic [1:0] pbank;
    logic [COLW-1:0] pcol;
    logic pap;
    logic [2:0] ppairs;
    logic [3:0] rd_blk;
    logic [3:0] wr_blk;
    logic [3:0] pre_blk;
    logic [3:0] any_blk;
    lpddr_pkg::cmd_e cmd;
    logic [1:0] bank;
    logic [COLW-1:0] col;
    logic ap;
    logic [2*W-1:0] dq;
    logic dq_oe;
    logic [1:0] dqs;
    logic dqs_oe;
    logic [1:0] dm;
    logic rd_valid;
    logic [2*W-1:0] rd_data;
    logic ready;
    logic busy;
  } ctl_s;
  ctl_s s_r, s_nxt;
  logic fifo_valid, fifo_pop, can_go;
  logic [2*W-1:0] fifo_data;
  logic [LW-1:0] fifo_level;

  // Saturating countdown
  function automatic logic [3:0] dec(input logic [3:0] v);
    dec = (v == 4'h0) ? 4'h0 : v - 4'h1;
  endfunction

  // Wanted pairs, zero or too many means whole burst
  function automatic logic [2:0] clamp(input logic [2:0] p);
    clamp = (p == 3'h0 || p > HALF) ? HALF : p;
  endfunction

  // Put the held request on the bus
  function automatic ctl_s issue(input ctl_s x);
    ctl_s y;
    y = x;
    y.pv = 1'b0;
    y.cmd = x.pop;
    y.bank = x.pbank;
    y.col = {x.pcol[COLW-1:1], 1'b0};
    y.ap = x.pap && x.pop != lpddr_pkg::cmd_precharge;
    case (x.pop)
      lpddr_pkg::cmd_read: begin
        y.st = lpddr_pkg::st_read;
        y.cnt = x.ppairs;
        y.pairs = x.ppairs;
      end
      lpddr_pkg::cmd_write: begin
        y.st = lpddr_pkg::st_write;
        y.cnt = HALF;
        y.pairs = x.ppairs;
        y.dqs_oe = 1'b1;
      end
      default: begin
        y.any_blk = 4'(`PRECHARGE_PERIOD_CLK);
      end
    endcase
    return y;
  endfunction

  lpddr_pair_fifo #(.W(2*W), .DEPTH(DEPTH)) u_wfifo (
    .i_clock(i_clock),
    .i_rstn(i_rstn),
    .i_ce(i_ce),
    .i_in_valid(i_wd_valid),
    .o_in_ready(o_wd_ready),
    .i_in_data(i_wd_data),
    .o_out_valid(fifo_valid),
    .i_out_ready(fifo_pop),
    .o_out_data(fifo_data),
    .o_level(fifo_level)
  );

  // Held request may go once its spacing is met
  always_comb begin
    case (s_r.pop)
      lpddr_pkg::cmd_read: can_go = s_r.rd_blk == 4'h0;
      lpddr_pkg::cmd_write: can_go = s_r.wr_blk == 4'h0;
      default: can_go = s_r.pre_blk == 4'h0;
    endcase
    can_go = can_go && s_r.pv && s_r.any_blk == 4'h0;
  end

  // Sequencer
  always_comb begin
    s_nxt = s_r;
    fifo_pop = 1'b0;
    s_nxt.cmd = lpddr_pkg::cmd_nop;
    s_nxt.dq_oe = 1'b0;
    s_nxt.dqs_oe = 1'b0;
    s_nxt.dqs = `STROBE_IDLE;
    s_nxt.dm = `MASK_NONE;
    s_nxt.rd_blk = dec(s_r.rd_blk);
    s_nxt.wr_blk = dec(s_r.wr_blk);
    s_nxt.pre_blk = dec(s_r.pre_blk);
    s_nxt.any_blk = dec(s_r.any_blk);
    // Read pairs arrive with the memory's strobe
    s_nxt.rd_valid = !s_r.dqs_oe && bus.dqs == `STROBE_TOGGLE;
    s_nxt.rd_data = bus.dq;
    case (s_r.st)
      lpddr_pkg::st_idle: begin
        if (can_go && (s_r.pop != lpddr_pkg::cmd_write ||
            fifo_level >= LW'(s_r.ppairs))) begin
          s_nxt = issue(s_nxt);
        end
      end
      lpddr_pkg::st_read: begin
        s_nxt.cnt = s_r.cnt - 3'h1;
        if (s_r.cnt == 3'h1) begin
          // Stop lands the same number of clocks late as the data
          if (s_r.pairs < HALF && BL > 2) begin
            s_nxt.cmd = lpddr_pkg::cmd_burst_stop;
          end
          s_nxt.st = lpddr_pkg::st_idle;
          s_nxt.wr_blk = 4'(RL + 1);
        end
      end
      lpddr_pkg::st_write: begin
        if (s_r.cnt != 3'h0) begin
          // One pair per clock, first rise one clock after the command
          s_nxt.dqs_oe = 1'b1;
          s_nxt.dq_oe = 1'b1;
          s_nxt.dqs = `STROBE_TOGGLE;
          s_nxt.cnt = s_r.cnt - 3'h1;
          if (s_r.pairs != 3'h0) begin
            fifo_pop = 1'b1;
            s_nxt.dq = fifo_data;
            s_nxt.pairs = s_r.pairs - 3'h1;
          end else begin
            s_nxt.dm = `MASK_ALL;
          end
          // Next write on the last pair keeps data continuous
          if (s_r.cnt == 3'h1 && can_go && s_r.pop == lpddr_pkg::cmd_write &&
              fifo_level >= LW'(s_r.ppairs) + LW'(s_r.pairs != 3'h0)) begin
            s_nxt = issue(s_nxt);
          end
        end else begin
          s_nxt.dqs_oe = 1'b1;
          s_nxt.st = lpddr_pkg::st_idle;
          s_nxt.rd_blk = 4'(`WRITE_TO_READ_GAP_CLK);
          s_nxt.pre_blk = 4'(`WRITE_RECOVERY_CLK);
        end
      end
      default: s_nxt.st = lpddr_pkg::st_idle;
    endcase
    // Take a new request while none is held
    if (s_r.ready && i_req_valid) begin
      s_nxt.pv = 1'b1;
      s_nxt.pop = i_req_op;
      s_nxt.pbank = i_req_bank;
      s_nxt.pcol = i_req_col;
      s_nxt.pap = i_req_ap;
      s_nxt.ppairs = clamp(i_req_pairs);
    end
    s_nxt.ready = !s_nxt.pv;
    s_nxt.busy = s_nxt.pv || s_nxt.st != lpddr_pkg::st_idle;
  end

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      s_r <= '0;
    end else if (i_ce) begin
      s_r <= s_nxt;
    end
  end

  // Bus and user outputs straight from state
  assign bus.cmd = s_r.cmd;
  assign bus.bank = s_r.bank;
  assign bus.col = s_r.col;
  assign bus.auto_precharge_addr_bit = s_r.ap;
  assign bus.write_data_mask = s_r.dm;
  assign bus.ctl_dq = s_r.dq;
  assign bus.ctl_dq_oe = s_r.dq_oe;
  assign bus.ctl_dqs = s_r.dqs;
  assign bus.ctl_dqs_oe = s_r.dqs_oe;
  assign o_req_ready = s_r.ready;
  assign o_rd_valid = s_r.rd_valid;
  assign o_rd_data = s_r.rd_data;
  assign o_busy = s_r.busy;
endmodule
`default_nettype wire

// file: lpddr_dev_end.sv
// Purpose: memory end, serves read and write bursts from a small array
// Assumes: rows already open, column given as element address
// Notes: bursts advance linearly, column wraps at its width
`timescale 1ns/1ns
`default_nettype none
`include "lpddr_consts.svh"
module lpddr_dev_end #(
  parameter int W = 8,
  parameter int COLW = 4,
  parameter int BL = `BURST_LENGTH_DEF,
  parameter int RL = `READ_LATENCY_DEF
) (
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire logic i_ce,
  output logic o_pre_start,
  output logic [1:0] o_pre_bank,
  output logic o_pair_stored,
  lpddr_bus.dev bus
);
  localparam logic [2:0] HALF = 3'(BL / 2);
  typedef struct packed {
    lpddr_pkg::cmd_e c;
    logic [1:0] b;
    logic [COLW-1:0] col;
  } dcmd_s;
  typedef struct packed {
    dcmd_s [RL-2:0] dly;
    logic [2:0] rd_left;
    logic [1:0] rd_bank;
    logic [COLW-1:0] rd_col;
    logic [2:0] wr_left;
    logic [1:0] wr_bank;
    logic [COLW-1:0] wr_col;
    logic wr_ap;
    logic [2:0] ap_cnt;
    logic [1:0] ap_bank;
    logic [2*W-1:0] dq;
    logic dq_oe;
    logic pre;
    logic [1:0] pre_bank;
    logic stored;
  } dev_s;
  dev_s s_r, s_nxt;
  logic [W-1:0] mem [2**(COLW+2)];
  logic we_lo, we_hi;
  logic [COLW+1:0] wa;
  dcmd_s cur, d;

  // Array index of an element
  function automatic logic [COLW+1:0] idx(input logic [1:0] b,
      input logic [COLW-1:0] c, input logic hi);
    idx = {b, c[COLW-1:1], hi};
  endfunction

  // Next pair column
  function automatic logic [COLW-1:0] step(input logic [COLW-1:0] c);
    step = c + {{(COLW-2){1'b0}}, 2'h2};
  endfunction

  assign cur = '{c: bus.cmd, b: bus.bank, col: bus.col};
  assign d = s_r.dly[RL-2];

  always_comb begin
    s_nxt = s_r;
    we_lo = 1'b0;
    we_hi = 1'b0;
    wa = idx(s_r.wr_bank, s_r.wr_col, 1'b0);
    s_nxt.dq_oe = 1'b0;
    s_nxt.pre = 1'b0;
    s_nxt.stored = 1'b0;
    // Commands age so read effects land read latency later
    for (int i = RL - 2; i > 0; i--) s_nxt.dly[i] = s_r.dly[i-1];
    s_nxt.dly[0] = cur;
    case (d.c)
      lpddr_pkg::cmd_read: begin
        s_nxt.rd_left = HALF;
        s_nxt.rd_bank = d.b;
        s_nxt.rd_col = d.col;
      end
      lpddr_pkg::cmd_burst_stop: begin
        if (BL > 2) s_nxt.rd_left = 3'h0;
      end
      lpddr_pkg::cmd_precharge: begin
        if (d.b == s_r.rd_bank) s_nxt.rd_left = 3'h0;
      end
      default: begin
      end
    endcase
    // Read pair out, RL clocks after the command
    if (s_nxt.rd_left != 3'h0) begin
      s_nxt.dq = {mem[idx(s_nxt.rd_bank, s_nxt.rd_col, 1'b1)],
                  mem[idx(s_nxt.rd_bank, s_nxt.rd_col, 1'b0)]};
      s_nxt.dq_oe = 1'b1;
      s_nxt.rd_col = step(s_nxt.rd_col);
      s_nxt.rd_left = s_nxt.rd_left - 3'h1;
    end
    // Pair taken on rise then fall, ignored once the burst is over
    if (s_r.wr_left != 3'h0 && bus.dqs == `STROBE_TOGGLE) begin
      we_lo = !bus.write_data_mask[0];
      we_hi = !bus.write_data_mask[1];
      s_nxt.stored = 1'b1;
      s_nxt.wr_col = step(s_r.wr_col);
      s_nxt.wr_left = s_r.wr_left - 3'h1;
      if (s_r.wr_left == 3'h1 && s_r.wr_ap) begin
        s_nxt.ap_cnt = 3'h1;
        s_nxt.ap_bank = s_r.wr_bank;
      end
    end
    // Auto precharge countdown
    if (s_r.ap_cnt != 3'h0) begin
      s_nxt.ap_cnt = s_r.ap_cnt - 3'h1;
      if (s_r.ap_cnt == 3'h1) begin
        s_nxt.pre = 1'b1;
        s_nxt.pre_bank = s_r.ap_bank;
      end
    end
    // New command at this edge
    case (cur.c)
      lpddr_pkg::cmd_write: begin
        s_nxt.wr_left = HALF;
        s_nxt.wr_bank = cur.b;
        s_nxt.wr_col = cur.col;
        s_nxt.wr_ap = bus.auto_precharge_addr_bit;
      end
      lpddr_pkg::cmd_read: begin
        s_nxt.wr_left = 3'h0;
        if (bus.auto_precharge_addr_bit) begin
          s_nxt.ap_cnt = HALF;
          s_nxt.ap_bank = cur.b;
        end
      end
      lpddr_pkg::cmd_precharge: begin
        if (cur.b == s_r.wr_bank) s_nxt.wr_left = 3'h0;
        s_nxt.pre = 1'b1;
        s_nxt.pre_bank = cur.b;
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      s_r <= '0;
    end else if (i_ce) begin
      s_r <= s_nxt;
    end
  end

  // Array write, masked elements keep old value
  always_ff @(posedge i_clock) begin
    if (i_ce && we_lo) mem[wa] <= bus.dq[W-1:0];
    if (i_ce && we_hi) mem[wa | {{(COLW+1){1'b0}}, 1'b1}] <= bus.dq[2*W-1:W];
  end

  assign bus.dev_dq = s_r.dq;
  assign bus.dev_dq_oe = s_r.dq_oe;
  assign bus.dev_dqs = s_r.dq_oe ? `STROBE_TOGGLE : `STROBE_IDLE;
  assign bus.dev_dqs_oe = s_r.dq_oe;
  assign o_pre_start = s_r.pre;
  assign o_pre_bank = s_r.pre_bank;
  assign o_pair_stored = s_r.stored;
endmodule
`default_nettype wire

// file: lpddr_burst_checker.sv
// Purpose: watches the command bus and data pins between both ends
// Assumes: burst length four, read latency two, one data pair per clock
// Notes: fixed delays follow those defaults of the two ends
`timescale 1ns/1ns
`default_nettype none
module lpddr_burst_checker (
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire lpddr_pkg::cmd_e cmd,
  input wire logic [1:0] write_data_mask,
  input wire logic ctl_dq_oe,
  input wire logic dev_dq_oe,
  input wire logic ctl_dqs_oe,
  input wire logic dev_dqs_oe,
  input wire logic [1:0] ctl_dqs,
  input wire logic [1:0] dev_dqs
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rstn);
  // Write strobe: two pairs from one clock after the command
  a_write_strobe_pairs: assert property (cmd == lpddr_pkg::cmd_write |=>
    (ctl_dqs_oe && ctl_dqs == 2'h2) [*2]) else $error("write strobe pairs missing");
  // Strobe held low after the last pair
  a_write_postamble: assert property ((ctl_dqs_oe && ctl_dqs == 2'h2) ##1
    !(ctl_dqs_oe && ctl_dqs == 2'h2) |-> ctl_dqs_oe && ctl_dqs == 2'h0)
    else $error("write postamble missing");
  // First read pair after the latency
  a_read_first_pair: assert property (cmd == lpddr_pkg::cmd_read |-> ##2
    (dev_dq_oe && dev_dqs_oe && dev_dqs == 2'h2)) else $error("read pair late");
  // Uncut read gives the whole burst
  a_read_full_burst: assert property (cmd == lpddr_pkg::cmd_read ##1
    (cmd != lpddr_pkg::cmd_burst_stop && cmd != lpddr_pkg::cmd_precharge) |->
    ##1 dev_dq_oe [*2]) else $error("read burst short");
  // Stop ends read data after the latency
  a_stop_cuts_read: assert property (cmd == lpddr_pkg::cmd_burst_stop |->
    ##2 !dev_dq_oe) else $error("read data after stop");
  // Never both ends on the data pins
  a_bus_one_driver: assert property (ctl_dq_oe |-> !dev_dq_oe)
    else $error("data pins driven by both ends");
  // Masked elements still strobed
  a_mask_strobed: assert property ((ctl_dq_oe && write_data_mask != 2'h0) |->
    write_data_mask == 2'h3 && ctl_dqs_oe && ctl_dqs == 2'h2)
    else $error("masked pair not strobed");
  // Gap after write data before read or precharge
  a_write_turn_gap: assert property ((ctl_dqs_oe && ctl_dqs == 2'h2) |=>
    (cmd != lpddr_pkg::cmd_read && cmd != lpddr_pkg::cmd_precharge) [*2])
    else $error("read or precharge too soon after write");
  // Quiet bus after precharge
  a_precharge_rest: assert property (cmd == lpddr_pkg::cmd_precharge |=>
    cmd == lpddr_pkg::cmd_nop) else $error("command inside precharge period");
endmodule
`default_nettype wire

// file: lpddr_burst_read_write_control_tb.sv
// Purpose: joins both ends, drives user side, checks against a model
// Assumes: default parameters of both ends: W 8, COLW 4, BL 4, RL 2, FIFO depth 4
// Notes: model updates memory when a request is taken, in order
`timescale 1ns/1ns
`default_nettype none
module lpddr_burst_read_write_control_tb;
  logic i_clock, i_rstn, i_ce, i_req_valid, i_req_ap, i_wd_valid;
  lpddr_pkg::cmd_e i_req_op;
  logic [1:0] i_req_bank, o_pre_bank;
  logic [3:0] i_req_col;
  logic [2:0] i_req_pairs;
  logic [15:0] i_wd_data, o_rd_data;
  logic o_req_ready, o_wd_ready, o_rd_valid, o_busy, o_pre_start, o_pair_stored;
  int n_errors = 0;
  int tests_run = 0;
  int cycles = 0;
  int stored = 0;
  int exp_stored = 0;
  int cols [4];
  logic [7:0] mem [int];
  logic [15:0] rq [$];
  logic [15:0] wq [$];
  logic [1:0] pq [$];
  lpddr_bus bus ();
  lpddr_ctl_end lpddr_ctl_end_inst (
    .i_clock(i_clock), .i_rstn(i_rstn), .i_ce(i_ce), .i_req_valid(i_req_valid),
    .i_req_op(i_req_op), .i_req_bank(i_req_bank), .i_req_col(i_req_col),
    .i_req_ap(i_req_ap), .i_req_pairs(i_req_pairs), .o_req_ready(o_req_ready),
    .i_wd_valid(i_wd_valid), .o_wd_ready(o_wd_ready), .i_wd_data(i_wd_data),
    .o_rd_valid(o_rd_valid), .o_rd_data(o_rd_data), .o_busy(o_busy), .bus(bus));
  lpddr_dev_end lpddr_dev_end_inst (
    .i_clock(i_clock), .i_rstn(i_rstn), .i_ce(i_ce), .o_pre_start(o_pre_start),
    .o_pre_bank(o_pre_bank), .o_pair_stored(o_pair_stored), .bus(bus));
  lpddr_burst_checker lpddr_burst_checker_inst (
    .i_clock(i_clock), .i_rstn(i_rstn), .cmd(bus.cmd), .write_data_mask(bus.write_data_mask),
    .ctl_dq_oe(bus.ctl_dq_oe), .dev_dq_oe(bus.dev_dq_oe), .ctl_dqs_oe(bus.ctl_dqs_oe),
    .dev_dqs_oe(bus.dev_dqs_oe), .ctl_dqs(bus.ctl_dqs), .dev_dqs(bus.dev_dqs));
  // Clock at 8 ns
  initial begin
    i_clock = 1'b0;
    forever #4 i_clock = ~i_clock;
  end
  // Compare and count
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      $display("unexpected %s: expected %h seen %h", what, exp, got);
      n_errors++;
    end
  endtask
  // Verdict and stop
  task automatic end_sim();
    if (n_errors == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // One write pair into the FIFO, held until taken
  task automatic push(input logic [15:0] d);
    wq.push_back(d);
    i_wd_valid = 1'b1;
    i_wd_data = d;
    while (o_wd_ready !== 1'b1) @(negedge i_clock);
    @(negedge i_clock);
    i_wd_valid = 1'b0;
    // Idle clock so a following push raises valid in a later time step
    @(negedge i_clock);
  endtask
  // One request, held until taken, then the model follows it
  task automatic req(input lpddr_pkg::cmd_e op, input int b, input int c, input logic ap,
    input int p);
    int n;
    int e;
    n = (p == 0 || p > 2) ? 2 : p;
    i_req_valid = 1'b1;
    i_req_op = op;
    i_req_bank = 2'(b);
    i_req_col = 4'(c);
    i_req_ap = ap;
    i_req_pairs = 3'(p);
    while (o_req_ready !== 1'b1) @(negedge i_clock);
    @(negedge i_clock);
    i_req_valid = 1'b0;
    for (int k = 0; k < n && op != lpddr_pkg::cmd_precharge; k++) begin
      e = b * 16 + (((c & 14) + 2 * k) % 16);
      if (op == lpddr_pkg::cmd_write) begin
        mem[e] = wq[0][7:0];
        mem[e + 1] = wq.pop_front() >> 8;
      end else rq.push_back({mem[e + 1], mem[e]});
    end
    if (op == lpddr_pkg::cmd_write) exp_stored += 2;
    if (ap || op == lpddr_pkg::cmd_precharge) pq.push_back(2'(b));
    // Idle clock so a following request raises valid in a later time step
    @(negedge i_clock);
  endtask
  // Pushes p random pairs then asks for the write
  task automatic wr(input int b, input int c, input logic ap, input int p);
    for (int k = 0; k < p; k++) push(16'($urandom));
    req(lpddr_pkg::cmd_write, b, c, ap, p);
  endtask
  // Result monitor and hang guard
  always @(negedge i_clock) begin
    cycles++;
    if (o_rd_valid === 1'b1) begin
      if (rq.size() == 0) chk("rd_valid", 16'h0000, 16'h0001);
      else chk("rd_data", rq.pop_front(), o_rd_data);
    end
    if (o_pre_start === 1'b1) begin
      if (pq.size() == 0) chk("pre_start", 16'h0000, 16'h0001);
      else chk("pre_bank", {14'h0000, pq.pop_front()}, {14'h0000, o_pre_bank});
    end
    if (o_pair_stored === 1'b1) stored++;
    if (cycles > 20000) begin
      chk("timeout", 16'h0000, 16'h0001);
      end_sim();
    end
  end
  // Main sequence
  initial begin
    i_rstn = 1'b0;
    i_ce = 1'b1;
    i_req_valid = 1'b0;
    i_req_op = lpddr_pkg::cmd_nop;
    i_req_bank = 2'h0;
    i_req_col = 4'h0;
    i_req_ap = 1'b0;
    i_req_pairs = 3'h0;
    i_wd_valid = 1'b0;
    i_wd_data = 16'h0000;
    void'($urandom(29));
    repeat (12) @(negedge i_clock);
    i_rstn = 1'b1;
    repeat (2) @(negedge i_clock);
    chk("wd_ready", 16'h0001, {15'h0000, o_wd_ready});
    // Full writes to every bank, then read back
    for (int b = 0; b < 4; b++) cols[b] = 2 * $urandom_range(7, 0);
    for (int b = 0; b < 4; b++) wr(b, cols[b], 1'b0, 2);
    for (int b = 0; b < 4; b++) req(lpddr_pkg::cmd_read, b, cols[b], 1'b0, 2);
    // FIFO filled until it refuses, then two writes drain it back to back
    for (int k = 0; k < 4; k++) push(16'($urandom));
    chk("wd_ready_full", 16'h0000, {15'h0000, o_wd_ready});
    req(lpddr_pkg::cmd_write, 2, (cols[2] + 4) % 16, 1'b0, 2);
    req(lpddr_pkg::cmd_write, 3, (cols[3] + 4) % 16, 1'b0, 2);
    req(lpddr_pkg::cmd_read, 2, (cols[2] + 4) % 16, 1'b0, 2);
    req(lpddr_pkg::cmd_read, 3, (cols[3] + 4) % 16, 1'b0, 2);
    // Short write masks its second pair
    wr(0, cols[0], 1'b0, 1);
    req(lpddr_pkg::cmd_read, 0, cols[0], 1'b0, 2);
    // Every wanted pair count, stop where short
    for (int p = 0; p < 4; p++) req(lpddr_pkg::cmd_read, 1, cols[1], 1'b0, p);
    // Auto precharge on read and write, then explicit precharge
    req(lpddr_pkg::cmd_read, 2, cols[2], 1'b1, 2);
    wr(3, cols[3], 1'b1, 2);
    req(lpddr_pkg::cmd_read, 1, cols[1], 1'b0, 2);
    req(lpddr_pkg::cmd_precharge, 1, 0, 1'b0, 0);
    while (o_busy !== 1'b0) @(negedge i_clock);
    repeat (12) @(negedge i_clock);
    // Clock enable low: a waiting read must not be taken
    i_ce = 1'b0;
    i_req_op = lpddr_pkg::cmd_read;
    i_req_valid = 1'b1;
    repeat (4) @(negedge i_clock);
    chk("req_ready_frozen", 16'h0001, {15'h0000, o_req_ready});
    chk("busy_frozen", 16'h0000, {15'h0000, o_busy});
    i_req_valid = 1'b0;
    i_ce = 1'b1;
    repeat (4) @(negedge i_clock);
    chk("reads_left", 16'h0000, 16'(rq.size()));
    chk("precharges_left", 16'h0000, 16'(pq.size()));
    chk("pairs_stored", 16'(exp_stored), 16'(stored));
    end_sim();
  end
endmodule
`default_nettype wire
